// ===== design/dds_sweep_regs.svh
// How it works
// - sweep runs only with auxiliary enable bit set
// - destination field picks frequency or phase target
// - control bit picks edge or level trigger
// - level trigger restarts sweep while input high
// - start and end points from limits register
// - 32-bit frequency, 14-bit MSB-aligned phase limits
// - profile low bits: off, up, down, both
// - parallel mode uses internal profile bits only
// - serial mode: control bit picks pins or bits
// - deltas 32 or 14 bits, rates 16 bits
// - rising words going up, falling going down
// - up: add rising delta per period until end
// - down: subtract falling delta until start point
// - step spacing is ramp rate in clocks
// - step size scales as delta over full range
// - accumulator overflow gives free-running sweep
// - no-dwell bit zeroes accumulator at end point
// - delta and rate rewrites apply to later steps
// - continuous clear holds accumulator at zero
// - auto-clear pulses auxiliary accumulator on update/change
// - auto-clear pulses phase accumulator on update/change
// - auto-clear repeats; both clears act independently
`ifndef DDS_SWEEP_REGS_SVH
`define DDS_SWEEP_REGS_SVH

// register addresses
`define ADDR_CTRL1       8'h00
`define ADDR_LIMITS      8'h06
`define ADDR_DELTAS      8'h07
`define ADDR_RATES       8'h08
`define ADDR_STATUS      8'h09

// first control register fields
`define CTRL1_CONT_CLR_PH   0
`define CTRL1_CONT_CLR_AUX  1
`define CTRL1_AUTO_CLR_PH   2
`define CTRL1_AUTO_CLR_AUX  3
`define CTRL1_NO_DWELL      8
`define CTRL1_LEVEL_TRIG    9
`define CTRL1_AUX_EN        11
`define CTRL1_DEST_LO       12
`define CTRL1_PROF_LO       20
`define CTRL1_PROF_INT      27

// reset values
`define CTRL1_RESET      32'h0000_0000
`define LIMITS_RESET     64'h0000_0000_0000_0000
`define DELTAS_RESET     64'h0000_0000_0000_0000
`define RATES_RESET      32'h0001_0001

// phase words sit in the top 14 bits
`define PHASE_MASK       32'hFFFC_0000
`define DEST_PHASE       2'h1

`endif

// ===== design/dds_sweep_pkg.sv
package dds_sweep_pkg;
    // sweep engine states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_UP,
        ST_DOWN,
        ST_HOLD
    } sweep_state_t;

    typedef logic [31:0] word_t;     // accumulator word
    typedef logic [15:0] rate_t;     // ramp-rate word
    typedef logic [2:0]  profile_t;  // profile selection
endpackage

// ===== design/sweep_step_if.sv
`timescale 1ns/1ps
// step timer link between sweep engine and its rate timer
interface sweep_step_if;
    logic        load;  // restart the timer
    logic [15:0] rate;  // ramp rate for the current direction
    logic        tick;  // step strobe
    modport timer (input load, input rate, output tick);
    modport ctrl  (output load, output rate, input tick);
endinterface

// ===== design/sweep_rate_timer.sv
`timescale 1ns/1ps
// counts ramp-rate clocks between sweep steps
module sweep_rate_timer #(
    parameter int RATE_W = 16
) (
    input  wire logic   core_clk_in,
    input  wire logic   nrst_in,
    sweep_step_if.timer step
);
    logic [RATE_W-1:0] cnt_r;     // clocks left in this step
    logic [RATE_W-1:0] rate_eff;  // zero rate behaves as one

    assign rate_eff = (step.rate == '0) ? RATE_W'(1) : step.rate;
    // tick on last clock; rate is read live at each reload
    assign step.tick = cnt_r <= RATE_W'(1);

    // reload picks up rewritten rates for later steps
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cnt_r <= RATE_W'(1);
        end else if (step.load || step.tick) begin
            cnt_r <= rate_eff;
        end else begin
            cnt_r <= cnt_r - RATE_W'(1);
        end
    end

    timer_reload_a: assert property (
        @(posedge core_clk_in) disable iff (!nrst_in)
        (step.load || step.tick) |=> cnt_r == $past(rate_eff))
        else $error("step timer reload wrong");
endmodule // sweep_rate_timer

// ===== design/accum_clear.sv
`timescale 1ns/1ps
// clear control for one accumulator
module accum_clear (
    input  wire logic core_clk_in,
    input  wire logic nrst_in,
    input  wire logic cont_en_in,   // continuous clear bit
    input  wire logic auto_en_in,   // clear-and-release bit
    input  wire logic update_in,    // register update strobe
    input  wire logic prof_chg_in,  // profile selection changed
    output logic      clear_out     // holds accumulator at zero
);
    // one-clock clear per event, repeated while bit stays set
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            clear_out <= 1'b0;
        end else begin
            clear_out <= cont_en_in
                | (auto_en_in & (update_in | prof_chg_in));
        end
    end

    auto_pulse_a: assert property (
        @(posedge core_clk_in) disable iff (!nrst_in)
        (auto_en_in && (update_in || prof_chg_in)) |=> clear_out)
        else $error("auto clear missed event");
    release_a: assert property (
        @(posedge core_clk_in) disable iff (!nrst_in)
        (!cont_en_in && !update_in && !prof_chg_in) |=> !clear_out)
        else $error("clear not released");
endmodule // accum_clear

// ===== design/dds_linear_sweep.sv
`timescale 1ns/1ps
`include "dds_sweep_regs.svh"
// linear sweep engine with accumulator clear logic
module dds_linear_sweep (
    input  wire logic              core_clk_in,
    input  wire logic              nrst_in,
    input  wire logic              wr_en_in,          // register write
    input  wire logic [7:0]        wr_addr_in,        // register address
    input  wire logic [63:0]       wr_data_in,        // write data
    input  wire logic [7:0]        rd_addr_in,        // read address
    output logic [63:0]            rd_data_out,       // read data
    input  wire logic              io_update_in,      // update strobe
    input  wire logic              parallel_mode_in,  // port mode
    input  wire dds_sweep_pkg::profile_t profile_pins_in,
    input  wire dds_sweep_pkg::word_t    frequency_tuning_word_in,
    input  wire logic [13:0]       phase_offset_word_in,
    output dds_sweep_pkg::word_t   freq_word_out,     // to dds core
    output logic [13:0]            phase_word_out,    // to dds core
    output dds_sweep_pkg::word_t   phase_acc_out,     // phase accum
    output logic                   sweep_active_out   // stepping
);
    import dds_sweep_pkg::*;

    logic [31:0]  first_control_register_r;  // mode and clear bits
    logic [63:0]  limits_r;                  // end:start
    logic [63:0]  deltas_r;                  // falling:rising
    logic [31:0]  rates_r;                   // falling:rising
    sweep_state_t state_r;                   // sweep engine state
    sweep_state_t state_nxt;
    word_t        acc_r;                     // auxiliary accumulator
    word_t        acc_nxt;
    word_t        phase_acc_r;               // phase accumulator
    profile_t     prof_sel;                  // chosen profile bits
    profile_t     prof_r;                    // previous selection
    logic         prof_chg;                  // selection changed
    logic         clr_aux;                   // aux clear from control
    logic         clr_ph;                    // phase clear
    logic         sweep_en;
    logic         level_trig;
    logic         no_dwell;
    logic         dest_phase;
    logic [1:0]   mode;                      // sweep direction code
    logic         up_go;                     // start an up ramp
    logic         down_go;                   // start a down ramp
    word_t        mask;                      // phase alignment mask
    word_t        start_pt;
    word_t        end_pt;
    word_t        rise_d;
    word_t        fall_d;
    logic [32:0]  sum;                       // carry shows overflow
    logic [32:0]  diff;                      // borrow shows underflow
    logic         tmr_load;

    sweep_step_if step ();

    // field aliases
    assign sweep_en   = first_control_register_r[`CTRL1_AUX_EN];
    assign level_trig = first_control_register_r[`CTRL1_LEVEL_TRIG];
    assign no_dwell   = first_control_register_r[`CTRL1_NO_DWELL];
    assign dest_phase = first_control_register_r[`CTRL1_DEST_LO +: 2]
                        == `DEST_PHASE;

    // parallel mode forces internal bits; serial mode lets bit choose
    assign prof_sel = (parallel_mode_in
                       || first_control_register_r[`CTRL1_PROF_INT])
                      ? first_control_register_r[`CTRL1_PROF_LO +: 3]
                      : profile_pins_in;
    assign mode     = prof_sel[1:0];
    assign prof_chg = prof_sel != prof_r;

    // phase words keep only the top 14 bits
    assign mask     = dest_phase ? `PHASE_MASK : 32'hFFFF_FFFF;
    assign start_pt = limits_r[31:0] & mask;
    assign end_pt   = limits_r[63:32] & mask;
    assign rise_d   = deltas_r[31:0] & mask;
    assign fall_d   = deltas_r[63:32] & mask;
    // accumulating the delta word gives steps of delta/2^32 of full
    // scale, the same scaling for frequency and for phase
    assign sum  = {1'b0, acc_r} + {1'b0, rise_d};
    assign diff = {1'b0, acc_r} - {1'b0, fall_d};

    // edge mode wants a rising profile bit, level mode the bit itself
    assign up_go   = mode[0]
                     & (level_trig ? prof_sel[0] : !prof_r[0]);
    assign down_go = mode[1]
                     & (level_trig ? prof_sel[1] : !prof_r[1]);

    // register writes land on the next edge, mid-sweep included; rates apply at the next timer reload
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            first_control_register_r <= `CTRL1_RESET;
            limits_r <= `LIMITS_RESET;
            deltas_r <= `DELTAS_RESET;
            rates_r  <= `RATES_RESET;
        end else if (wr_en_in) begin
            if (wr_addr_in == `ADDR_CTRL1) begin
                first_control_register_r <= wr_data_in[31:0];
            end else if (wr_addr_in == `ADDR_LIMITS) begin
                limits_r <= wr_data_in;
            end else if (wr_addr_in == `ADDR_DELTAS) begin
                deltas_r <= wr_data_in;
            end else if (wr_addr_in == `ADDR_RATES) begin
                rates_r <= wr_data_in[31:0];
            end
        end
    end

    // registered read-back; unmapped addresses read zero
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rd_data_out <= 64'h0;
        end else if (rd_addr_in == `ADDR_CTRL1) begin
            rd_data_out <= {32'h0, first_control_register_r};
        end else if (rd_addr_in == `ADDR_LIMITS) begin
            rd_data_out <= limits_r;
        end else if (rd_addr_in == `ADDR_DELTAS) begin
            rd_data_out <= deltas_r;
        end else if (rd_addr_in == `ADDR_RATES) begin
            rd_data_out <= {32'h0, rates_r};
        end else if (rd_addr_in == `ADDR_STATUS) begin
            rd_data_out <= {30'h0, state_r, acc_r};
        end else begin
            rd_data_out <= 64'h0;
        end
    end

    // last profile selection, for edges and change detection
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            prof_r <= 3'h0;
        end else begin
            prof_r <= prof_sel;
        end
    end

    // independent clear controls, one per accumulator
    accum_clear aux_clear (
        .core_clk_in (core_clk_in),
        .nrst_in     (nrst_in),
        .cont_en_in  (first_control_register_r[`CTRL1_CONT_CLR_AUX]),
        .auto_en_in  (first_control_register_r[`CTRL1_AUTO_CLR_AUX]),
        .update_in   (io_update_in),
        .prof_chg_in (prof_chg),
        .clear_out   (clr_aux)
    );

    accum_clear ph_clear (
        .core_clk_in (core_clk_in),
        .nrst_in     (nrst_in),
        .cont_en_in  (first_control_register_r[`CTRL1_CONT_CLR_PH]),
        .auto_en_in  (first_control_register_r[`CTRL1_AUTO_CLR_PH]),
        .update_in   (io_update_in),
        .prof_chg_in (prof_chg),
        .clear_out   (clr_ph)
    );

    sweep_rate_timer #(.RATE_W(16)) timer (
        .core_clk_in (core_clk_in),
        .nrst_in     (nrst_in),
        .step        (step.timer)
    );

    // timer rate follows the direction being entered or held
    assign step.load = tmr_load;
    assign step.rate = (state_nxt == ST_DOWN) ? rates_r[31:16]
                                              : rates_r[15:0];

    // sweep engine next state
    always_comb begin
        state_nxt = state_r;
        acc_nxt   = acc_r;
        tmr_load  = 1'b0;
        if (clr_aux) begin
            state_nxt = ST_IDLE;
            acc_nxt   = 32'h0;
        end else if (!sweep_en || mode == 2'b00) begin
            state_nxt = ST_IDLE;
        end else begin
            case (state_r)
                ST_IDLE, ST_HOLD: begin
                    // hold state restarts only on level or a new edge
                    if (up_go) begin
                        state_nxt = ST_UP;
                        acc_nxt   = start_pt;
                        tmr_load  = 1'b1;
                    end else if (down_go) begin
                        state_nxt = ST_DOWN;
                        acc_nxt   = end_pt;
                        tmr_load  = 1'b1;
                    end
                end
                ST_UP: begin
                    if (step.tick) begin
                        // a carry wraps past the limit and runs free
                        if (!sum[32] && sum[31:0] >= end_pt) begin
                            acc_nxt = no_dwell ? 32'h0 : end_pt;
                            if (mode == 2'b11) begin
                                state_nxt = ST_DOWN;
                                tmr_load  = 1'b1;
                            end else begin
                                state_nxt = ST_HOLD;
                            end
                        end else begin
                            acc_nxt = sum[31:0];
                        end
                    end
                end
                ST_DOWN: begin
                    if (step.tick) begin
                        if (diff[32] || diff[31:0] <= start_pt) begin
                            acc_nxt = start_pt;
                            if (mode == 2'b11) begin
                                state_nxt = ST_UP;
                                tmr_load  = 1'b1;
                            end else begin
                                state_nxt = ST_HOLD;
                            end
                        end else begin
                            acc_nxt = diff[31:0];
                        end
                    end
                end
                default: begin
                    state_nxt = ST_IDLE;
                end
            endcase
        end
    end

    // sweep engine state registers
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_r <= ST_IDLE;
            acc_r   <= 32'h0;
        end else begin
            state_r <= state_nxt;
            acc_r   <= acc_nxt;
        end
    end

    // phase accumulator, cleared by its own control
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            phase_acc_r <= 32'h0;
        end else if (clr_ph) begin
            phase_acc_r <= 32'h0;
        end else begin
            phase_acc_r <= 32'(phase_acc_r + freq_word_out);
        end
    end

    // sweep output replaces the programmed word of its destination
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            freq_word_out  <= 32'h0;
            phase_word_out <= 14'h0;
        end else begin
            freq_word_out  <= (sweep_en && !dest_phase)
                              ? acc_r : frequency_tuning_word_in;
            phase_word_out <= (sweep_en && dest_phase)
                              ? acc_r[31:18] : phase_offset_word_in;
        end
    end

    assign phase_acc_out    = phase_acc_r;
    assign sweep_active_out = (state_r == ST_UP) || (state_r == ST_DOWN);

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!nrst_in);

    // an up step that lands on or past the end point
    sequence up_hits_end_s;
        state_r == ST_UP && step.tick && !clr_aux && sweep_en
        && mode != 2'b00 && !sum[32] && sum[31:0] >= end_pt;
    endsequence

    sequence down_hits_start_s;
        state_r == ST_DOWN && step.tick && !clr_aux && sweep_en
        && mode != 2'b00 && (diff[32] || diff[31:0] <= start_pt);
    endsequence

    sweep_off_idle_a: assert property (
        !sweep_en |=> state_r == ST_IDLE && !sweep_active_out)
        else $error("sweep ran while disabled");
    up_end_clamp_a: assert property (
        up_hits_end_s and !no_dwell |=> acc_r == $past(end_pt))
        else $error("up sweep missed end point");
    no_dwell_zero_a: assert property (
        up_hits_end_s and no_dwell |=> acc_r == 32'h0)
        else $error("no-dwell did not zero");
    down_start_clamp_a: assert property (
        down_hits_start_s |=> acc_r == $past(start_pt))
        else $error("down sweep missed start point");
    level_restart_a: assert property (
        (state_r == ST_HOLD && !clr_aux && sweep_en && level_trig
         && mode == 2'b01 && prof_sel[0])
        |=> state_r == ST_UP && acc_r == $past(start_pt))
        else $error("level sweep did not restart");
    cont_clear_zero_a: assert property (
        first_control_register_r[`CTRL1_CONT_CLR_AUX]
        ##1 first_control_register_r[`CTRL1_CONT_CLR_AUX]
        |=> acc_r == 32'h0 && state_r == ST_IDLE)
        else $error("continuous clear not holding");
    parallel_source_a: assert property (
        parallel_mode_in
        |-> prof_sel == first_control_register_r[`CTRL1_PROF_LO +: 3])
        else $error("parallel mode used pins");
    freq_route_a: assert property (
        (sweep_en && !dest_phase) |=> freq_word_out == $past(acc_r))
        else $error("sweep not routed to frequency");
    up_step_a: assert property (
        (state_r == ST_UP && step.tick && !clr_aux && sweep_en
         && mode != 2'b00 && (sum[32] || sum[31:0] < end_pt))
        |=> acc_r == $past(sum[31:0]))
        else $error("up step size wrong");

    // a down step that stays above the start point
    down_step_a: assert property (
        (state_r == ST_DOWN && step.tick && !clr_aux && sweep_en
         && mode != 2'b00 && !diff[32] && diff[31:0] > start_pt)
        |=> acc_r == $past(diff[31:0]))
        else $error("down step size wrong");

    // no movement between timer ticks
    step_hold_a: assert property (
        ((state_r == ST_UP || state_r == ST_DOWN) && !step.tick
         && !clr_aux && sweep_en && mode != 2'b00)
        |=> $stable(acc_r))
        else $error("accumulator moved between steps");

    // mode 00 parks the engine and keeps the word
    mode_off_a: assert property (
        (sweep_en && mode == 2'b00 && !clr_aux)
        |=> state_r == ST_IDLE && $stable(acc_r))
        else $error("sweep ran with mode off");

    // phase route mirrors the frequency route
    phase_route_a: assert property (
        (sweep_en && dest_phase)
        |=> phase_word_out == $past(acc_r[31:18]))
        else $error("sweep not routed to phase");

    // phase clear lands one edge after the clear register
    phase_clear_a: assert property (
        clr_ph |=> phase_acc_r == 32'h0)
        else $error("phase accumulator not cleared");
endmodule // dds_linear_sweep

// ===== verification/host_ctrl_model.sv
`timescale 1ns/1ps
// host controller: programs registers, strobes update, drives profile pins
module host_ctrl_model (
    input  wire logic        core_clk_in,
    output logic             wr_en_out,          // write strobe
    output logic [7:0]       wr_addr_out,        // write address
    output logic [63:0]      wr_data_out,        // write data
    output logic             io_update_out,      // update strobe
    output logic             parallel_mode_out,  // port mode
    output logic [2:0]       profile_pins_out    // external profile pins
);
    // quiet bus at time zero
    initial begin
        wr_en_out = 1'b0;
        wr_addr_out = 8'h00;
        wr_data_out = 64'h0;
        io_update_out = 1'b0;
        parallel_mode_out = 1'b1;
        profile_pins_out = 3'h0;
    end

    // one-cycle write; deltas kept well below full scale minus end
    task automatic wr(input logic [7:0] a, input logic [63:0] d);
        @(negedge core_clk_in);
        wr_en_out = 1'b1;
        wr_addr_out = a;
        wr_data_out = d;
        @(negedge core_clk_in);
        wr_en_out = 1'b0;
        // released data must not look valid, so drive the inverse
        wr_data_out = ~d;
    endtask

    // single update pulse, used only by the clear logic
    task automatic upd();
        @(negedge core_clk_in);
        io_update_out = 1'b1;
        @(negedge core_clk_in);
        io_update_out = 1'b0;
    endtask

    // port mode and pins change together off the sampling edge
    task automatic pins(input logic par, input logic [2:0] p);
        @(negedge core_clk_in);
        parallel_mode_out = par;
        profile_pins_out = p;
    endtask
endmodule // host_ctrl_model

// ===== verification/dds_linear_sweep_tb.sv
`timescale 1ns/1ps
`include "dds_sweep_regs.svh"
// self-checking bench for the linear sweep engine
module dds_linear_sweep_tb;
    import dds_sweep_pkg::*;
    logic               core_clk;    // 20 MHz system clock
    logic               nrst;        // async reset, active low
    logic               wr_en;       // host write strobe
    logic [7:0]         wr_addr;     // host write address
    logic [63:0]        wr_data;     // host write data
    logic [7:0]         rd_addr;     // bench read address
    logic [63:0]        rd_data;     // registered read data
    logic               io_update;   // update strobe
    logic               par_mode;    // port mode
    profile_t           pins;        // profile pins
    word_t              frequency_tuning_word;         // programmed tuning word
    logic [13:0]        phase_offset_word;         // programmed offset word
    word_t              freq_word;   // swept frequency word
    word_t              phase_acc;   // phase accumulator
    logic [13:0]        ph_word;     // routed phase word
    logic               act;         // sweep stepping
    logic               watch;       // monitor armed
    logic [63:0]        fq[$];       // expected frequency word changes
    logic [63:0]        rq[$];       // expected read or snapshot values
    int                 errors;      // mismatches
    int                 cmp_count;   // comparisons
    logic [31:0]        rnd;         // random register value
    localparam logic [31:0] EN = 32'h1 << `CTRL1_AUX_EN; // sweep on

    // 50 ns period
    always #25 core_clk = ~core_clk;

    host_ctrl_model host_u (
        .core_clk_in       (core_clk),
        .wr_en_out         (wr_en),
        .wr_addr_out       (wr_addr),
        .wr_data_out       (wr_data),
        .io_update_out     (io_update),
        .parallel_mode_out (par_mode),
        .profile_pins_out  (pins)
    );

    dds_linear_sweep dut_u (
        .core_clk_in              (core_clk),
        .nrst_in                  (nrst),
        .wr_en_in                 (wr_en),
        .wr_addr_in               (wr_addr),
        .wr_data_in               (wr_data),
        .rd_addr_in               (rd_addr),
        .rd_data_out              (rd_data),
        .io_update_in             (io_update),
        .parallel_mode_in         (par_mode),
        .profile_pins_in          (pins),
        .frequency_tuning_word_in (frequency_tuning_word),
        .phase_offset_word_in     (phase_offset_word),
        .freq_word_out            (freq_word),
        .phase_word_out           (ph_word),
        .phase_acc_out            (phase_acc),
        .sweep_active_out         (act)
    );

    // verdict and end of run
    task automatic conclude();
        if (errors == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // one compare for every kind of result
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // read one register, next-edge data
    task automatic rd(input logic [7:0] a, input logic [63:0] e);
        @(negedge core_clk);
        rd_addr = a;
        rq.push_back(e);
        @(negedge core_clk);
        chk(rd_data, rq.pop_front());
    endtask

    // bounded wait until every noted step has shown up
    task automatic drain();
        int n;
        n = 0;
        while (fq.size() != 0 && n < 400) begin
            @(negedge core_clk);
            n++;
        end
        if (fq.size() != 0) begin
            errors++;
            $display("[FAIL] %0t sweep stalled", $time);
            conclude();
        end
    endtask

    // each change of the swept word must be the oldest note
    always @(freq_word) begin
        if (watch) begin
            if (fq.size() == 0) chk(freq_word, 64'hDEAD);
            else chk(freq_word, fq.pop_front());
        end
    end

    initial begin
        core_clk = 1'b0;
        nrst = 1'b0;
        rd_addr = 8'h00;
        watch = 1'b0;
        errors = 0;
        cmp_count = 0;
        rnd = $urandom(34411);
        frequency_tuning_word = $urandom | 32'h1;
        phase_offset_word = 14'($urandom);
        repeat (20) @(posedge core_clk);
        @(negedge core_clk);
        nrst = 1'b1;
        // reset values, unmapped read, random write and read back
        rd(`ADDR_RATES, 64'h0000_0000_0001_0001);
        rd(`ADDR_LIMITS, 64'h0);
        rd(8'h05, 64'h0);
        rnd = $urandom;
        host_u.wr(`ADDR_RATES, {32'h0, rnd});
        rd(`ADDR_RATES, {32'h0, rnd});
        host_u.wr(`ADDR_DELTAS, {$urandom, rnd});
        host_u.wr(`ADDR_LIMITS, {32'h0000_000A, 32'h0});
        host_u.wr(`ADDR_DELTAS, {32'h3, 32'h4});
        host_u.wr(`ADDR_RATES, {32'h0, 16'h1, 16'h2});
        // parallel mode: internal bits steer even though pins are selected
        watch = 1'b1;
        fq = '{64'h0, 64'h4, 64'h8, 64'hA};
        host_u.wr(`ADDR_CTRL1, EN | (32'h1 << `CTRL1_PROF_LO));
        drain();
        chk({63'h0, act}, 64'h0);
        // continuous clear zeroes the held end value
        fq.push_back(64'h0);
        host_u.wr(`ADDR_CTRL1, EN | (32'h1 << `CTRL1_PROF_LO) | 32'h2);
        drain();
        host_u.wr(`ADDR_CTRL1, EN | (32'h1 << `CTRL1_PROF_LO));
        // down sweep with falling words, clamping at the start point
        fq = '{64'hA, 64'h7, 64'h4, 64'h1, 64'h0};
        host_u.wr(`ADDR_CTRL1, EN | (32'h2 << `CTRL1_PROF_LO));
        drain();
        // serial mode from the pins, top bit ignored, no-dwell
        host_u.wr(`ADDR_CTRL1, EN | (32'h1 << `CTRL1_NO_DWELL));
        host_u.pins(1'b0, 3'h4);
        fq = '{64'h4, 64'h8, 64'h0};
        host_u.pins(1'b0, 3'h5);
        drain();
        // level trigger restarts while the pin stays high
        fq = '{64'h4, 64'h8, 64'hA, 64'h0, 64'h4, 64'h8, 64'hA};
        host_u.wr(`ADDR_CTRL1, EN | (32'h1 << `CTRL1_LEVEL_TRIG));
        @(negedge core_clk);
        chk({63'h0, act}, 64'h1);
        drain();
        watch = 1'b0;
        host_u.pins(1'b0, 3'h4);
        // auto-clear of both accumulators, repeated on each update
        host_u.wr(`ADDR_CTRL1, (32'h1 << `CTRL1_AUTO_CLR_PH)
                  | (32'h1 << `CTRL1_AUTO_CLR_AUX));
        chk({50'h0, ph_word}, {50'h0, phase_offset_word});
        repeat (2) begin
            repeat (5) @(posedge core_clk);
            host_u.upd();
            @(negedge core_clk);
            rq.push_back(64'h0);
            chk({32'h0, phase_acc}, rq.pop_front());
        end
        rd(`ADDR_STATUS, 64'h0);
        repeat (3) @(negedge core_clk);
        chk({32'h0, phase_acc} != 64'h0, 64'h1);
        // phase destination while parked, phase held by continuous clear
        host_u.wr(`ADDR_CTRL1, EN | (32'h1 << `CTRL1_DEST_LO)
                  | (32'h1 << `CTRL1_CONT_CLR_PH));
        repeat (2) @(negedge core_clk);
        chk({50'h0, ph_word}, 64'h0);
        chk({32'h0, freq_word}, {32'h0, frequency_tuning_word});
        chk({32'h0, phase_acc}, 64'h0);
        conclude();
    end
endmodule // dds_linear_sweep_tb
